// >>> logic/lcc_cmd_decoder.sv
// Command and parameter decoder filling the LCD configuration registers
`timescale 1ns/1ps
`default_nettype none

//
// Operation
// - Command 40h: first parameter bit 0 picks internal character ROM, in register 00h.
// - Register 00h bit 2 eight-line chars, bit 3 two-panel, bit 5 top-line comp.
// - Register 01h bits 3-0 hold cell width minus one.
// - Register 01h bit 7 selects two-frame AC drive.
// - Register 02h bits 3-0 hold cell height minus one.
// - Register 03h holds display addresses per line minus one.
// - Register 04h holds total addresses per line, fifth setup parameter.
// - Register 05h holds lines per frame minus one.
// - Registers 06h/07h hold 16-bit virtual width, low byte first.
// - Command 44h: parameters one and two load block 1 start, 0Bh/0Ch.
// - Third scroll parameter sets block 1 line count in 0Dh.
// - Scroll parameters 4-6: block 2 start 0Eh/0Fh and line count 10h.
// - Scroll parameters 7-10: block 3 start 11h/12h, block 4 start 13h/14h.
// - Command 5Ah stores its parameter bits 2-0 in register 1Bh.
// - Command 5Bh stores parameter in 18h; bits 1-0 choose layer combination.
// - Register 18h bit 2 block 1 mode, bit 3 block 3 mode.
// - Write with A0 high is a command; A0 low is a parameter.
// - Size and count fields mean programmed value plus one.
module lcc_cmd_decoder
	import lcc_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire lcc_host_wr_t host_wr,
	output var  lcc_cfg_t     cfg,
	output var  logic         cmd_active
);

	logic [7:0]  regs_reg [REG_COUNT];
	lcc_state_t  state_reg;
	logic [4:0]  ptr_reg;
	logic [4:0]  last_reg;
	logic        wr_en;
	logic [4:0]  wr_addr;
	logic [7:0]  wr_data;

	// Field mask per register; only 1Bh clears bits above bit 2, every other register stores all eight bits
	function automatic logic [7:0] field_mask(input logic [4:0] a);
		if (a == REG_PIX_SHIFT)
			return MASK_PIX_SHIFT;
		return 8'hff;
	endfunction : field_mask

	// Parameter lands at the command's cursor only while a sequence is open
	always_comb begin
		wr_en   = host_wr.wr && !host_wr.a0 && (state_reg != LCC_IDLE);
		wr_addr = ptr_reg;
		wr_data = host_wr.data & field_mask(ptr_reg);
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg <= LCC_IDLE;
			ptr_reg   <= REG_SYS_MODE;
			last_reg  <= REG_SYS_MODE;
		end else if (host_wr.wr && host_wr.a0) begin
			unique case (host_wr.data)
				CMD_SYS_SETUP: begin
					state_reg <= LCC_SYS;
					ptr_reg   <= REG_SYS_MODE;
					last_reg  <= REG_VIRT_HIGH;
				end
				CMD_SCROLL: begin
					state_reg <= LCC_SCROLL;
					ptr_reg   <= REG_BLK1_LOW;
					last_reg  <= REG_BLK4_HIGH;
				end
				CMD_PIXEL_SHIFT: begin
					state_reg <= LCC_SINGLE;
					ptr_reg   <= REG_PIX_SHIFT;
					last_reg  <= REG_PIX_SHIFT;
				end
				CMD_OVERLAY: begin
					state_reg <= LCC_SINGLE;
					ptr_reg   <= REG_LAYER_COMB;
					last_reg  <= REG_LAYER_COMB;
				end
				// Commands outside this block close any open sequence
				default: state_reg <= LCC_IDLE;
			endcase
		end else if (wr_en) begin
			// Extra parameters past the last register are dropped
			if (ptr_reg == last_reg)
				state_reg <= LCC_IDLE;
			else
				ptr_reg <= ptr_reg + 5'd1;
		end
	end

	generate
		for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst)
					regs_reg[i] <= ZERO_BYTE;
				else if (wr_en && wr_addr == 5'(i))
					regs_reg[i] <= wr_data;
			end
		end
	endgenerate

	// Output copy is registered so the engine sees settled fields
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cfg        <= '0;
			cmd_active <= 1'b0;
		end else begin
			cmd_active          <= (state_reg != LCC_IDLE);
			cfg.cgen_source_sel <= regs_reg[REG_SYS_MODE][BIT_CGEN_SRC];
			cfg.char_lines_sel  <= regs_reg[REG_SYS_MODE][BIT_CHAR_LINES];
			cfg.two_panel_sel   <= regs_reg[REG_SYS_MODE][BIT_TWO_PANEL];
			cfg.top_line_comp   <= regs_reg[REG_SYS_MODE][BIT_TOP_COMP];
			cfg.ac_drive_sel    <= regs_reg[REG_CHAR_WIDTH][BIT_AC_DRIVE];
			// Fields stay in minus-one form; consumers add one
			cfg.cell_width      <= regs_reg[REG_CHAR_WIDTH][3:0];
			cfg.cell_height     <= regs_reg[REG_CHAR_HEIGHT][3:0];
			cfg.line_addr_cnt   <= regs_reg[REG_LINE_ADDR];
			cfg.line_total_cnt  <= regs_reg[REG_LINE_TOTAL];
			cfg.frame_lines     <= regs_reg[REG_FRAME_LINES];
			cfg.virtual_width   <= {regs_reg[REG_VIRT_HIGH], regs_reg[REG_VIRT_LOW]};
			cfg.block1_start    <= {regs_reg[REG_BLK1_HIGH], regs_reg[REG_BLK1_LOW]};
			cfg.block1_lines    <= regs_reg[REG_BLK1_LINES];
			cfg.block2_start    <= {regs_reg[REG_BLK2_HIGH], regs_reg[REG_BLK2_LOW]};
			cfg.block2_lines    <= regs_reg[REG_BLK2_LINES];
			cfg.block3_start    <= {regs_reg[REG_BLK3_HIGH], regs_reg[REG_BLK3_LOW]};
			cfg.block4_start    <= {regs_reg[REG_BLK4_HIGH], regs_reg[REG_BLK4_LOW]};
			cfg.layer_combine   <= regs_reg[REG_LAYER_COMB][1:0];
			cfg.block1_text_sel <= regs_reg[REG_LAYER_COMB][BIT_BLK1_TEXT];
			cfg.block3_text_sel <= regs_reg[REG_LAYER_COMB][BIT_BLK3_TEXT];
			cfg.pixel_shift     <= regs_reg[REG_PIX_SHIFT][2:0];
		end
	end

	sequence s_setup_cmd;
		host_wr.wr && host_wr.a0 && host_wr.data == CMD_SYS_SETUP;
	endsequence

	sequence s_param(logic [7:0] d);
		host_wr.wr && !host_wr.a0 && host_wr.data == d;
	endsequence

	sequence s_any_param;
		host_wr.wr && !host_wr.a0;
	endsequence

	sequence s_cmd(logic [7:0] c);
		host_wr.wr && host_wr.a0 && host_wr.data == c;
	endsequence

	// 38h leaves bits 0 and 2 clear and sets bits 3 and 5
	a_setup_first_param: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_setup_cmd ##1 s_param(8'h38) |=> ##1 cfg.cgen_source_sel == 1'b0
			&& !cfg.char_lines_sel && cfg.two_panel_sel && cfg.top_line_comp)
		else $error("setup first parameter not decoded");

	// Width and drive live in the second setup parameter, not the first
	a_width_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_setup_cmd ##1 s_any_param ##1 s_param(8'h87)
			|=> ##1 cfg.cell_width == 4'h7 && cfg.ac_drive_sel)
		else $error("cell width or AC drive wrong");

	a_setup_cursor: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_setup_cmd |=> ptr_reg == REG_SYS_MODE && last_reg == REG_VIRT_HIGH
			&& state_reg == LCC_SYS)
		else $error("setup cursor not opened");

	a_scroll_range: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_cmd(CMD_SCROLL) |=> last_reg == REG_BLK4_HIGH && state_reg == LCC_SCROLL)
		else $error("scroll range wrong");

	a_shift_open: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_cmd(CMD_PIXEL_SHIFT) |=> ptr_reg == REG_PIX_SHIFT && state_reg == LCC_SINGLE)
		else $error("pixel shift cursor wrong");

	a_overlay_open: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_cmd(CMD_OVERLAY) |=> ptr_reg == REG_LAYER_COMB && state_reg == LCC_SINGLE)
		else $error("overlay cursor wrong");

	// Any other code ends the sequence so later bytes cannot land anywhere
	a_unknown_closes: assert property (@(posedge clk_sys) disable iff (!nrst)
		host_wr.wr && host_wr.a0 && host_wr.data != CMD_SYS_SETUP
			&& host_wr.data != CMD_SCROLL && host_wr.data != CMD_PIXEL_SHIFT
			&& host_wr.data != CMD_OVERLAY |=> state_reg == LCC_IDLE)
		else $error("unknown command left sequence open");

	a_last_closes: assert property (@(posedge clk_sys) disable iff (!nrst)
		wr_en && ptr_reg == last_reg |=> state_reg == LCC_IDLE)
		else $error("sequence open past last register");

	a_active_follows: assert property (@(posedge clk_sys) disable iff (!nrst)
		##1 cmd_active == $past(state_reg != LCC_IDLE))
		else $error("command active flag out of step");

	a_copy_virtual: assert property (@(posedge clk_sys) disable iff (!nrst)
		##1 cfg.virtual_width == $past({regs_reg[REG_VIRT_HIGH], regs_reg[REG_VIRT_LOW]}))
		else $error("virtual width copy wrong");

	a_copy_height: assert property (@(posedge clk_sys) disable iff (!nrst)
		##1 cfg.cell_height == $past(regs_reg[REG_CHAR_HEIGHT][3:0]))
		else $error("cell height copy wrong");

	a_copy_line: assert property (@(posedge clk_sys) disable iff (!nrst)
		##1 cfg.line_addr_cnt == $past(regs_reg[REG_LINE_ADDR])
			&& cfg.line_total_cnt == $past(regs_reg[REG_LINE_TOTAL]))
		else $error("line counts copy wrong");

	a_copy_frame: assert property (@(posedge clk_sys) disable iff (!nrst)
		##1 cfg.frame_lines == $past(regs_reg[REG_FRAME_LINES]))
		else $error("frame lines copy wrong");

	a_copy_block2: assert property (@(posedge clk_sys) disable iff (!nrst)
		##1 cfg.block2_lines == $past(regs_reg[REG_BLK2_LINES])
			&& cfg.block2_start == $past({regs_reg[REG_BLK2_HIGH], regs_reg[REG_BLK2_LOW]}))
		else $error("second block copy wrong");

	a_copy_block1: assert property (@(posedge clk_sys) disable iff (!nrst)
		##1 cfg.block1_lines == $past(regs_reg[REG_BLK1_LINES]))
		else $error("first block lines copy wrong");

	a_copy_shift: assert property (@(posedge clk_sys) disable iff (!nrst)
		##1 cfg.pixel_shift == $past(regs_reg[REG_PIX_SHIFT][2:0]))
		else $error("pixel shift copy wrong");

	a_cmd_opens_seq: assert property (@(posedge clk_sys) disable iff (!nrst)
		host_wr.wr && host_wr.a0 && (host_wr.data == CMD_SCROLL
			|| host_wr.data == CMD_OVERLAY) |=> ##1 cmd_active)
		else $error("command did not open sequence");

	a_scroll_start_ptr: assert property (@(posedge clk_sys) disable iff (!nrst)
		host_wr.wr && host_wr.a0 && host_wr.data == CMD_SCROLL |=> ptr_reg == REG_BLK1_LOW)
		else $error("scroll cursor not at first block");

	a_param_advance: assert property (@(posedge clk_sys) disable iff (!nrst)
		wr_en && ptr_reg != last_reg && !(host_wr.wr && host_wr.a0)
			|=> ptr_reg == $past(ptr_reg) + 5'd1)
		else $error("parameter cursor did not advance");

	a_param_store: assert property (@(posedge clk_sys) disable iff (!nrst)
		wr_en |=> regs_reg[$past(wr_addr)] == $past(wr_data))
		else $error("parameter not stored");

	a_shift_masked: assert property (@(posedge clk_sys) disable iff (!nrst)
		regs_reg[REG_PIX_SHIFT][7:3] == 5'h00)
		else $error("pixel shift high bits set");

	a_single_closes: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg == LCC_SINGLE && wr_en && !host_wr.a0 |=> state_reg == LCC_IDLE)
		else $error("single parameter command did not close");

	a_overlay_fields: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_cmd(CMD_OVERLAY) ##1 s_param(8'h01)
			|=> ##1 cfg.layer_combine == 2'b01 && !cfg.block1_text_sel && !cfg.block3_text_sel)
		else $error("overlay fields wrong");

	// A stray parameter must leave the register under the cursor untouched
	a_idle_ignores: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_reg == LCC_IDLE && s_any_param
			|=> regs_reg[$past(ptr_reg)] == $past(regs_reg[ptr_reg]))
		else $error("parameter accepted with no command");

endmodule : lcc_cmd_decoder

`default_nettype wire

// >>> logic/lcc_pkg.sv
// Package: codes, register offsets and field layout for the LCD command decoder
package lcc_pkg;
	localparam logic [7:0] CMD_SYS_SETUP   = 8'h40;
	localparam logic [7:0] CMD_SCROLL      = 8'h44;
	localparam logic [7:0] CMD_PIXEL_SHIFT = 8'h5a;
	localparam logic [7:0] CMD_OVERLAY     = 8'h5b;

	localparam logic [4:0] REG_SYS_MODE    = 5'h00;
	localparam logic [4:0] REG_CHAR_WIDTH  = 5'h01;
	localparam logic [4:0] REG_CHAR_HEIGHT = 5'h02;
	localparam logic [4:0] REG_LINE_ADDR   = 5'h03;
	localparam logic [4:0] REG_LINE_TOTAL  = 5'h04;
	localparam logic [4:0] REG_FRAME_LINES = 5'h05;
	localparam logic [4:0] REG_VIRT_LOW    = 5'h06;
	localparam logic [4:0] REG_VIRT_HIGH   = 5'h07;
	localparam logic [4:0] REG_BLK1_LOW    = 5'h0b;
	localparam logic [4:0] REG_BLK1_HIGH   = 5'h0c;
	localparam logic [4:0] REG_BLK1_LINES  = 5'h0d;
	localparam logic [4:0] REG_BLK2_LOW    = 5'h0e;
	localparam logic [4:0] REG_BLK2_HIGH   = 5'h0f;
	localparam logic [4:0] REG_BLK2_LINES  = 5'h10;
	localparam logic [4:0] REG_BLK3_LOW    = 5'h11;
	localparam logic [4:0] REG_BLK3_HIGH   = 5'h12;
	localparam logic [4:0] REG_BLK4_LOW    = 5'h13;
	localparam logic [4:0] REG_BLK4_HIGH   = 5'h14;
	localparam logic [4:0] REG_LAYER_COMB  = 5'h18;
	localparam logic [4:0] REG_PIX_SHIFT   = 5'h1b;
	localparam int         REG_COUNT       = 32;

	localparam int BIT_CGEN_SRC    = 0;
	localparam int BIT_CHAR_LINES  = 2;
	localparam int BIT_TWO_PANEL   = 3;
	localparam int BIT_TOP_COMP    = 5;
	localparam int BIT_AC_DRIVE    = 7;
	localparam int BIT_BLK1_TEXT   = 2;
	localparam int BIT_BLK3_TEXT   = 3;
	localparam logic [7:0] MASK_PIX_SHIFT = 8'h07;
	localparam logic [7:0] ZERO_BYTE      = 8'h00;

	typedef enum logic [1:0] {
		LCC_IDLE,
		LCC_SYS,
		LCC_SCROLL,
		LCC_SINGLE
	} lcc_state_t;

	// One host write: A0 selects command (1) or parameter (0)
	typedef struct packed {
		logic       wr;
		logic       a0;
		logic [7:0] data;
	} lcc_host_wr_t;

	// Decoded configuration handed to the display engine
	typedef struct packed {
		logic        cgen_source_sel;
		logic        char_lines_sel;
		logic        two_panel_sel;
		logic        top_line_comp;
		logic        ac_drive_sel;
		logic [3:0]  cell_width;
		logic [3:0]  cell_height;
		logic [7:0]  line_addr_cnt;
		logic [7:0]  line_total_cnt;
		logic [7:0]  frame_lines;
		logic [15:0] virtual_width;
		logic [15:0] block1_start;
		logic [7:0]  block1_lines;
		logic [15:0] block2_start;
		logic [7:0]  block2_lines;
		logic [15:0] block3_start;
		logic [15:0] block4_start;
		logic [1:0]  layer_combine;
		logic        block1_text_sel;
		logic        block3_text_sel;
		logic [2:0]  pixel_shift;
	} lcc_cfg_t;
endpackage : lcc_pkg

// >>> test/lcc_cmd_decoder_tb.sv
// Self-checking bench for the LCD command decoder
`timescale 1ns/1ps
`default_nettype none
module lcc_cmd_decoder_tb;
	import lcc_pkg::*;
	logic         clk_sys;
	logic         nrst;
	logic         chk;
	lcc_host_wr_t host_wr;
	lcc_cfg_t     cfg;
	lcc_cfg_t     exp_cfg;
	logic         cmd_active;
	lcc_cfg_t     exp_q[$];
	logic [7:0]   prm[$];
	logic [7:0]   codes[4];
	int           mismatches;
	int           num_checks;
	int           seed;

	lcc_cmd_decoder uut (.clk_sys(clk_sys), .nrst(nrst), .host_wr(host_wr),
		.cfg(cfg), .cmd_active(cmd_active));
	lcc_host_model host (.clk_sys(clk_sys), .host_wr(host_wr));

	task automatic note(input logic [7:0] code, input int i, input logic [7:0] p);
		if (code == CMD_SYS_SETUP) begin
			case (i)
			0: begin
				exp_cfg.cgen_source_sel = p[0];
				exp_cfg.char_lines_sel  = p[2];
				exp_cfg.two_panel_sel   = p[3];
				exp_cfg.top_line_comp   = p[5];
			end
			1: {exp_cfg.ac_drive_sel, exp_cfg.cell_width} = {p[7], p[3:0]};
			2: exp_cfg.cell_height = p[3:0];
			3: exp_cfg.line_addr_cnt = p;
			4: exp_cfg.line_total_cnt = p;
			5: exp_cfg.frame_lines = p;
			6: exp_cfg.virtual_width[7:0] = p;
			7: exp_cfg.virtual_width[15:8] = p;
			default: ;
			endcase
		end
		if (code == CMD_SCROLL) begin
			case (i)
			0: exp_cfg.block1_start[7:0] = p;
			1: exp_cfg.block1_start[15:8] = p;
			2: exp_cfg.block1_lines = p;
			3: exp_cfg.block2_start[7:0] = p;
			4: exp_cfg.block2_start[15:8] = p;
			5: exp_cfg.block2_lines = p;
			6: exp_cfg.block3_start[7:0] = p;
			7: exp_cfg.block3_start[15:8] = p;
			8: exp_cfg.block4_start[7:0] = p;
			9: exp_cfg.block4_start[15:8] = p;
			default: ;
			endcase
		end
		if (code == CMD_PIXEL_SHIFT && i == 0)
			exp_cfg.pixel_shift = p[2:0];
		if (code == CMD_OVERLAY && i == 0)
			{exp_cfg.block3_text_sel, exp_cfg.block1_text_sel, exp_cfg.layer_combine} = p[3:0];
	endtask : note

	// Fixed wait: a stored byte reaches cfg one edge after it is taken
	task automatic settle(input string name);
		host.idle();
		repeat (3) @(posedge clk_sys);
		exp_q.push_back(exp_cfg);
		chk <= 1'b1;
		@(posedge clk_sys);
		chk <= 1'b0;
		$display("test %s done", name);
	endtask : settle

	task automatic run(input string name, input logic [7:0] code);
		host.put(1'b1, code);
		foreach (prm[i]) begin
			host.put(1'b0, prm[i]);
			note(code, i, prm[i]);
		end
		settle(name);
	endtask : run

	task automatic cmp_cfg(input string what, input lcc_cfg_t e, input lcc_cfg_t s);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask : cmp_cfg

	task automatic cmp_bit(input string what, input logic e, input logic s);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %b seen %b", what, e, s);
		end
	endtask : cmp_bit

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	always @(posedge clk_sys) begin
		if (chk) begin
			cmp_cfg("cfg", exp_q.pop_front(), cfg);
			cmp_bit("cmd_active", 1'b0, cmd_active);
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		#10000;
		mismatches++;
		print_verdict();
	end

	initial begin
		seed = 32'h626a;
		mismatches = 0;
		num_checks = 0;
		chk = 1'b0;
		nrst = 1'b0;
		exp_cfg = '0;
		codes = '{CMD_SYS_SETUP, CMD_SCROLL, CMD_PIXEL_SHIFT, CMD_OVERLAY};
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		settle("reset_values");
		// Host order: setup, scroll, shift, overlay; trailing bytes must be dropped
		prm = {8'h38, 8'h87, 8'h07, 8'h3f, 8'h49, 8'h7f, 8'h80, 8'h00, 8'hff};
		run("setup", CMD_SYS_SETUP);
		prm = {8'h00, 8'h00, 8'h40, 8'h00, 8'h10, 8'h40, 8'h00, 8'h04, 8'h00, 8'h30, 8'h55};
		run("scroll", CMD_SCROLL);
		prm = {8'hff, 8'h03};
		run("shift", CMD_PIXEL_SHIFT);
		prm = {8'h01};
		run("overlay", CMD_OVERLAY);
		// Memory fill bytes after a foreign command must not reach the registers
		prm = {8'h20, 8'h00};
		run("unknown", 8'h42);
		for (int k = 0; k < 8; k++) begin
			prm = {};
			repeat (11) prm.push_back(8'($random(seed)));
			run("random", codes[k % 4]);
		end
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		exp_cfg = '0;
		settle("mid_reset");
		print_verdict();
	end
endmodule : lcc_cmd_decoder_tb
`default_nettype wire

// >>> test/lcc_host_model.sv
// Host processor model writing command and parameter bytes
`timescale 1ns/1ps
`default_nettype none
module lcc_host_model
	import lcc_pkg::*;
(
	input  wire logic         clk_sys,
	output var  lcc_host_wr_t host_wr
);
	initial host_wr = '0;

	task automatic put(input logic a0, input logic [7:0] data);
		@(posedge clk_sys);
		host_wr <= '{wr: 1'b1, a0: a0, data: data};
	endtask : put

	// Released lines do not keep the last byte, so stale data cannot pass
	task automatic idle();
		@(posedge clk_sys);
		host_wr <= '{wr: 1'b0, a0: ~host_wr.a0, data: ~host_wr.data};
	endtask : idle
endmodule : lcc_host_model
`default_nettype wire
